// ==== logic/divide_code_table.v ====
// Decodes the nonlinear divider and line-pulse codes into decimal ratios.
`timescale 1ns/1ps
module divide_code_table (
  input wire [7:0] divider_code,
  input wire [7:0] width_code,
  output reg [7:0] divide_ratio,
  output reg [7:0] pulse_periods
);
  // Only the documented entries are fixed; other divider codes extrapolate as code plus two, other width codes as twice code.
  always @* begin
    if (divider_code == 8'h00) begin
      divide_ratio = 8'h02; // [RULE6]
    end else if (divider_code == 8'h02) begin
      divide_ratio = 8'h04; // [RULE6]
    end else begin
      divide_ratio = divider_code + 8'h02;
    end
    if (width_code == 8'h29) begin
      pulse_periods = 8'h52; // [RULE10]
    end else if (width_code == 8'h01) begin
      pulse_periods = 8'h02; // [RULE10]
    end else begin
      pulse_periods = {width_code[6:0], 1'b0};
    end
  end
endmodule

// ==== logic/lcd_timing_consts.vh ====
// Offsets, field positions, reset values and timing constants of the panel timing generator.
`ifndef LCD_TIMING_CONSTS_VH
`define LCD_TIMING_CONSTS_VH
`define OFS_MODE 12'h000
`define OFS_BYTE_COUNT 12'h004
`define OFS_PULSE_WIDTH 12'h008
`define OFS_LINES 12'h00C
`define OFS_DIVIDER 12'h010
`define OFS_AC_WIDTH 12'h014
`define OFS_UPPER_ADDR 12'h018
`define OFS_LOWER_ADDR 12'h01C
`define OFS_STATUS 12'h020
`define OFS_PIXEL 12'h024
`define MODE_BIN4_DIV 8'h83
`define MODE_BIN8_DIV 8'h87
`define MODE_GRAY4_DIV 8'h8B
`define MODE_BIN4_OR 8'h93
`define MODE_BIN8_OR 8'h97
`define MODE_GRAY4_OR 8'h9B
`define MODE_BIN_DUAL 8'hA3
`define MODE_BIT_ENABLE 7
`define MODE_BIT_WIDE 2
`define MODE_BIT_GRAY 3
`define MODE_BIT_DUAL 5
`define RST_MODE 8'h00
`define RST_BYTE_COUNT 8'h27
`define RST_PULSE_WIDTH 8'h01
`define RST_LINES 10'h0EF
`define RST_DIVIDER 8'h00
`define RST_AC_WIDTH 10'h000
`define FRAME_PULSE_LINES 10'h001
`endif

// ==== logic/lcd_timing_gen.v ====
// Passive panel timing generator with APB registers and a pixel word port.
// Behaviour
// [RULE1] Mode 0x83 is binary 4-bit division single scan; 0x87 same at 8 bits.
// [RULE2] Mode 0x8B is gray 4-bit division single scan; byte count doubles.
// [RULE3] Mode 0x93 is binary 4-bit OR single scan; 0x97 same at 8 bits.
// [RULE4] Mode 0x9B is gray 4-bit OR single scan.
// [RULE5] Each shift clock carries four or eight data bits by transfer width.
// [RULE6] Divider code maps nonlinearly to ratio: 0x00 gives 2, 0x02 gives 4.
// [RULE7] Byte count field holds bytes per line minus one.
// [RULE8] Ten-bit lines field holds line pulses per frame minus one.
// [RULE9] Software sets lines to rows, or half rows in dual scan.
// [RULE10] Pulse width code maps nonlinearly: 0x29 gives 82, 0x01 gives 2.
// [RULE11] Line is data time, width plus half pulse, plus half period gap.
// [RULE12] Frame is line period times lines; one frame pulse per frame.
// [RULE13] Software keeps decoded pulse width at least two.
// [RULE14] Mode 0xA3 is binary dual scan using two start addresses. Here it runs as 4-bit binary single scan and only passes both addresses out.
// [RULE15] AC-drive toggles only on line pulse falling edge, every set count.
// [RULE16] Line pulse follows the shifted bytes; frame pulse marks first line.
// [RULE17] Shift clock runs only during data; data stable half period each side.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "lcd_timing_consts.vh"
module lcd_timing_gen (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] pixel_word,
  input wire pixel_valid,
  output wire pixel_ready,
  output reg frame_pulse,
  output reg line_pulse,
  output reg shift_clock,
  output reg ac_drive_clock,
  output reg [7:0] panel_data_bus,
  output wire [31:0] upper_screen_start_address,
  output wire [31:0] lower_screen_start_address
);
  localparam ST_IDLE = 2'b00;
  localparam ST_DATA = 2'b01;
  localparam ST_PULSE = 2'b10;
  localparam ST_GAP = 2'b11;

  reg [7:0] display_mode_select;
  reg [7:0] line_byte_count;
  reg [7:0] line_pulse_width;
  reg [9:0] lines_per_frame;
  reg [7:0] reference_clock_divider;
  reg [9:0] ac_drive_width;
  reg [31:0] upper_addr;
  reg [31:0] lower_addr;
  reg [1:0] state;
  reg [7:0] ref_count;
  reg [1:0] phase;
  reg [9:0] xfer_count;
  reg [9:0] xfer_total;
  reg [8:0] pulse_count;
  reg [9:0] line_count;
  reg [9:0] ac_count;
  reg [7:0] shift_word;
  reg second_nibble;
  reg have_word;
  reg underrun;
  wire [7:0] divide_ratio;
  wire [7:0] pulse_periods;
  wire enabled;
  wire wide;
  wire gray;
  wire mode_ok;
  wire ref_tick;
  wire half_tick;
  wire write_en;
  wire [3:0] phases;
  wire [9:0] next_xfer_total;
  wire [3:0] nibble;
  wire single_xfer;
  wire byte_take;

  divide_code_table codes (
    .divider_code(reference_clock_divider),
    .width_code(line_pulse_width),
    .divide_ratio(divide_ratio),
    .pulse_periods(pulse_periods)
  );

  // Only the documented mode codes start the generator; anything else holds it idle.
  assign mode_ok = (display_mode_select == `MODE_BIN4_DIV) ||
    (display_mode_select == `MODE_BIN8_DIV) ||
    (display_mode_select == `MODE_GRAY4_DIV) ||
    (display_mode_select == `MODE_BIN4_OR) ||
    (display_mode_select == `MODE_BIN8_OR) ||
    (display_mode_select == `MODE_GRAY4_OR) ||
    (display_mode_select == `MODE_BIN_DUAL); // [RULE1] [RULE3] [RULE4] [RULE14]
  assign enabled = mode_ok && display_mode_select[`MODE_BIT_ENABLE];
  assign wide = display_mode_select[`MODE_BIT_WIDE] &&
    !display_mode_select[`MODE_BIT_GRAY]; // [RULE1] [RULE3]
  assign gray = display_mode_select[`MODE_BIT_GRAY]; // [RULE2] [RULE4]
  // A gray byte holds four two-bit pixels and feeds one 4-bit transfer, which is why
  // the byte count doubles; a binary byte needs two transfers at 4 bits, one at 8.
  assign single_xfer = wide || gray; // [RULE2] [RULE5]
  assign next_xfer_total = single_xfer ? {2'b00, line_byte_count} :
    {1'b0, line_byte_count, 1'b1}; // [RULE5] [RULE7] [RULE11]
  // Shift period: 2 reference ticks at 4 bits, 4 at 8 bits; each phase is half of that.
  assign phases = wide ? 4'h4 : 4'h2;
  assign ref_tick = clk_en && enabled && (ref_count == divide_ratio - 8'h01); // [RULE6]
  assign half_tick = ref_tick && ({2'b00, phase} + 4'h1 == {1'b0, phases[3:1]});
  assign nibble = second_nibble ? shift_word[3:0] : shift_word[7:4];
  // A frozen block must not offer to take a byte that it would then miss.
  assign pixel_ready = clk_en && enabled && !have_word;
  assign byte_take = pixel_valid && pixel_ready;
  assign write_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign upper_screen_start_address = upper_addr; // [RULE14]
  assign lower_screen_start_address = lower_addr; // [RULE14]

  // Register writes and reads are both frozen with clk_en, so a stalled bus sees no change.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_mode_select <= `RST_MODE;
      line_byte_count <= `RST_BYTE_COUNT;
      line_pulse_width <= `RST_PULSE_WIDTH;
      lines_per_frame <= `RST_LINES;
      reference_clock_divider <= `RST_DIVIDER;
      ac_drive_width <= `RST_AC_WIDTH;
      upper_addr <= 32'h00000000;
      lower_addr <= 32'h00000000;
    end else if (clk_en && write_en) begin
      if (paddr == `OFS_MODE) begin
        display_mode_select <= pwdata[7:0];
      end else if (paddr == `OFS_BYTE_COUNT) begin
        line_byte_count <= pwdata[7:0]; // [RULE7]
      end else if (paddr == `OFS_PULSE_WIDTH) begin
        line_pulse_width <= pwdata[7:0];
      end else if (paddr == `OFS_LINES) begin
        lines_per_frame <= pwdata[9:0]; // [RULE8]
      end else if (paddr == `OFS_DIVIDER) begin
        reference_clock_divider <= pwdata[7:0];
      end else if (paddr == `OFS_AC_WIDTH) begin
        ac_drive_width <= pwdata[9:0];
      end else if (paddr == `OFS_UPPER_ADDR) begin
        upper_addr <= pwdata;
      end else if (paddr == `OFS_LOWER_ADDR) begin
        lower_addr <= pwdata;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      if (paddr == `OFS_MODE) begin
        prdata <= {24'h000000, display_mode_select};
      end else if (paddr == `OFS_BYTE_COUNT) begin
        prdata <= {24'h000000, line_byte_count};
      end else if (paddr == `OFS_PULSE_WIDTH) begin
        prdata <= {24'h000000, line_pulse_width};
      end else if (paddr == `OFS_LINES) begin
        prdata <= {22'h0, lines_per_frame};
      end else if (paddr == `OFS_DIVIDER) begin
        prdata <= {24'h000000, reference_clock_divider};
      end else if (paddr == `OFS_AC_WIDTH) begin
        prdata <= {22'h0, ac_drive_width};
      end else if (paddr == `OFS_UPPER_ADDR) begin
        prdata <= upper_addr;
      end else if (paddr == `OFS_LOWER_ADDR) begin
        prdata <= lower_addr;
      end else if (paddr == `OFS_STATUS) begin
        prdata <= {underrun, 19'h0, state, line_count};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Timing engine; each state step lasts one half shift period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      ref_count <= 8'h00;
      phase <= 2'b00;
      xfer_count <= 10'h000;
      xfer_total <= 10'h000;
      pulse_count <= 9'h000;
      line_count <= 10'h000;
      ac_count <= 10'h000;
      shift_word <= 8'h00;
      second_nibble <= 1'b0;
      have_word <= 1'b0;
      underrun <= 1'b0;
      frame_pulse <= 1'b0;
      line_pulse <= 1'b0;
      shift_clock <= 1'b0;
      ac_drive_clock <= 1'b0;
      panel_data_bus <= 8'h00;
    end else if (clk_en) begin
      if (byte_take) begin
        have_word <= 1'b1;
        shift_word <= pixel_word;
      end
      // The clear is scheduled first, so a missing byte in the same cycle still sets the flag.
      if (write_en && paddr == `OFS_STATUS && pwdata[31]) begin
        underrun <= 1'b0;
      end
      if (!enabled) begin
        state <= ST_IDLE;
        ref_count <= 8'h00;
        phase <= 2'b00;
        shift_clock <= 1'b0;
        line_pulse <= 1'b0;
        frame_pulse <= 1'b0;
      end else begin
        ref_count <= ref_tick ? 8'h00 : ref_count + 8'h01;
        if (ref_tick) begin
          phase <= half_tick ? 2'b00 : phase + 2'b01;
        end
      end
      if (half_tick) begin
        case (state)
          ST_IDLE: begin
            // Leaving idle always starts a fresh frame, so each frame the panel sees begins at its first line.
            xfer_total <= next_xfer_total;
            xfer_count <= 10'h000;
            line_count <= 10'h000;
            second_nibble <= 1'b0;
            frame_pulse <= 1'b1; // [RULE16]
            state <= ST_DATA;
          end
          ST_DATA: begin
            // Data goes out with the rising edge and holds through the high and next low half,
            // so it stands half a period before and after the falling edge.
            if (!shift_clock) begin
              if (wide) begin
                panel_data_bus <= shift_word; // [RULE5] [RULE17]
              end else begin
                panel_data_bus <= {4'h0, nibble}; // [RULE5] [RULE17]
              end
              // With no byte held the stale one goes out and the miss is flagged.
              if (!have_word) begin
                underrun <= 1'b1;
              end
              shift_clock <= 1'b1; // [RULE17]
            end else begin
              shift_clock <= 1'b0;
              xfer_count <= xfer_count + 10'h001;
              // A byte taken on this very edge belongs to the next transfer, so keep it.
              if ((single_xfer || second_nibble) && !byte_take) begin
                have_word <= 1'b0; // [RULE2] [RULE5]
              end
              second_nibble <= single_xfer ? 1'b0 : !second_nibble;
              if (xfer_count == xfer_total) begin
                line_pulse <= 1'b1; // [RULE11] [RULE16]
                // One extra half period realises the width-plus-half high time.
                pulse_count <= {pulse_periods, 1'b0};
                state <= ST_PULSE;
              end
            end
          end
          ST_PULSE: begin
            if (pulse_count == 9'h000) begin
              line_pulse <= 1'b0; // [RULE11]
              state <= ST_GAP;
              if (ac_count == ac_drive_width) begin
                ac_count <= 10'h000;
                ac_drive_clock <= !ac_drive_clock; // [RULE15]
              end else begin
                ac_count <= ac_count + 10'h001;
              end
            end else begin
              pulse_count <= pulse_count - 9'h001;
            end
          end
          default: begin
            // Half period gap before the next line's first shift edge.
            xfer_count <= 10'h000;
            xfer_total <= next_xfer_total;
            second_nibble <= 1'b0;
            state <= ST_DATA; // [RULE11]
            if (line_count == lines_per_frame) begin
              line_count <= 10'h000; // [RULE8] [RULE12]
              frame_pulse <= 1'b1; // [RULE12] [RULE16]
            end else begin
              line_count <= line_count + 10'h001;
              if (line_count + 10'h001 >= `FRAME_PULSE_LINES) begin
                frame_pulse <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// ==== verif/lcd_timing_gen_sva.sv ====
// Port checker for the panel timing generator.
`timescale 1ns/1ps
module lcd_timing_chk (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire pready,
  input wire pslverr,
  input wire pixel_ready,
  input wire frame_pulse,
  input wire line_pulse,
  input wire shift_clock,
  input wire ac_drive_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_at_once_a: assert property (pready) else $error("APB answer late");
  no_bus_error_a: assert property (!pslverr) else $error("APB error answer");
  freeze_hold_a: assert property (!clk_en |=>
    $stable({frame_pulse, line_pulse, shift_clock, ac_drive_clock}))
    else $error("Panel outputs moved while frozen");
  pixel_gate_a: assert property (!clk_en |-> !pixel_ready) else $error("Byte taken while frozen");
  shift_idle_a: assert property (line_pulse |-> !shift_clock)
    else $error("Shift clock high during line pulse");
  shift_half_a: assert property ($changed(shift_clock) |=> $stable(shift_clock))
    else $error("Shift clock half period under two cycles");
  line_width_a: assert property ($rose(line_pulse) |=> line_pulse[*8])
    else $error("Line pulse too short");
  ac_on_fall_a: assert property ($changed(ac_drive_clock) |-> $fell(line_pulse))
    else $error("AC clock moved away from line pulse fall");
  frame_in_data_a: assert property ($rose(frame_pulse) |-> !line_pulse)
    else $error("Frame pulse rose inside line pulse");
  cover property ($rose(frame_pulse));
  cover property ($fell(line_pulse));
  cover property ($changed(ac_drive_clock));
endmodule
bind lcd_timing_gen lcd_timing_chk i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .pready(pready), .pslverr(pslverr), .pixel_ready(pixel_ready), .frame_pulse(frame_pulse),
  .line_pulse(line_pulse), .shift_clock(shift_clock), .ac_drive_clock(ac_drive_clock));

// ==== verif/lcd_timing_gen_test.sv ====
// Self-checking bench for the panel timing generator.
`timescale 1ns/1ps
`include "lcd_timing_consts.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module lcd_timing_gen_test;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pixel_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0] pixel_word, d0, d1;
  wire [31:0] prdata, up_addr, lo_addr;
  wire pready, pslverr, pixel_ready, frame_pulse, line_pulse, shift_clock, ac_clk;
  wire [7:0] panel_data_bus;
  int error_cnt, checked, shifts, width, period, lines, half, sh;
  int rst_v[5] = '{0, 32'h27, 32'h01, 32'hEF, 0};
  logic [7:0] md[8] = '{8'h83, 8'h87, 8'h8B, 8'h93, 8'h97, 8'h9B, 8'hA3, 8'h83};
  int dv[8] = '{0, 0, 0, 0, 0, 0, 0, 2};
  int ratio[8] = '{2, 2, 2, 2, 2, 2, 2, 4};
  int wc[8] = '{1, 1, 1, 1, 1, 1, 1, 8'h29};
  int wd[8] = '{2, 2, 2, 2, 2, 2, 2, 82};
  lcd_timing_gen i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pixel_word(pixel_word), .pixel_valid(pixel_valid),
    .pixel_ready(pixel_ready), .frame_pulse(frame_pulse), .line_pulse(line_pulse),
    .shift_clock(shift_clock), .ac_drive_clock(ac_clk), .panel_data_bus(panel_data_bus),
    .upper_screen_start_address(up_addr), .lower_screen_start_address(lo_addr));
  panel_model i_panel (.pclk(pclk), .frame_pulse(frame_pulse), .line_pulse(line_pulse),
    .shift_clock(shift_clock), .panel_data_bus(panel_data_bus), .shifts(shifts),
    .width(width), .period(period), .lines(lines), .d0(d0), .d1(d1));
  task automatic end_sim;
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic frames(input int k);
    int n;
    repeat (k) begin
      n = 0;
      while (frame_pulse !== 1'b0 && n < 20000) begin @(posedge pclk); n++; end
      while (frame_pulse !== 1'b1 && n < 20000) begin @(posedge pclk); n++; end
      if (n >= 20000) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    clk_en = 1;
    pixel_word = 8'hA5;
    pixel_valid = 1;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(0, 12'(4 * i), 32'h0);
      `CHK("reset", rst_v[i], rd)
    end
    apb(0, 12'h030, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    apb(1, `OFS_UPPER_ADDR, 32'h12345678);
    `CHK("upper", 32'h12345678, up_addr)
    apb(1, `OFS_LOWER_ADDR, 32'h9ABCDEF0);
    `CHK("lower", 32'h9ABCDEF0, lo_addr)
    apb(0, `OFS_UPPER_ADDR, 32'h0);
    `CHK("upper_rd", 32'h12345678, rd)
    apb(1, `OFS_BYTE_COUNT, 32'h01);
    apb(1, `OFS_LINES, 32'h002);
    apb(1, `OFS_AC_WIDTH, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1, `OFS_MODE, 32'h0);
      apb(1, `OFS_DIVIDER, dv[i]);
      apb(1, `OFS_PULSE_WIDTH, wc[i]);
      apb(1, `OFS_MODE, md[i]);
      frames(3);
      half = md[i][2] ? 2 * ratio[i] : ratio[i];
      sh = (md[i][2] | md[i][3]) ? 2 : 4;
      `CHK("shifts", sh, shifts)
      `CHK("width", (2 * wd[i] + 1) * half, width)
      `CHK("period", half * (2 * sh + 2 * wd[i] + 2), period)
      `CHK("lines", 3, lines)
      if (!md[i][3]) begin
        `CHK("data0", md[i][2] ? 8'hA5 : 8'h0A, d0)
        `CHK("data1", md[i][2] ? 8'hA5 : 8'h05, d1)
      end
    end
    // Freezing just after a frame pulse rises, before the first shift edge, must hold the frame, line, shift and AC clock outputs where they stand.
    clk_en <= 0;
    repeat (6) @(posedge pclk);
    clk_en <= 1;
    repeat (2) @(posedge pclk);
    end_sim();
  end
endmodule

// ==== verif/panel_model.sv ====
// Behavioural panel that measures line, pulse and frame timing.
`timescale 1ns/1ps
module panel_model (
  input wire pclk,
  input wire frame_pulse,
  input wire line_pulse,
  input wire shift_clock,
  input wire [7:0] panel_data_bus,
  output int shifts,
  output int width,
  output int period,
  output int lines,
  output logic [7:0] d0,
  output logic [7:0] d1
);
  // Sampled on the fast clock, so figures come out in pclk cycles.
  int s_cnt = 0, w_cnt = 0, p_cnt = 0, l_cnt = 0;
  logic lp_q = 0, sc_q = 0, fp_q = 0;
  always @(posedge pclk) begin
    lp_q <= line_pulse;
    sc_q <= shift_clock;
    fp_q <= frame_pulse;
    p_cnt <= p_cnt + 1;
    if (shift_clock && !sc_q) begin
      if (s_cnt == 0) d0 <= panel_data_bus;
      if (s_cnt == 1) d1 <= panel_data_bus;
      s_cnt <= s_cnt + 1;
    end
    if (line_pulse) w_cnt <= w_cnt + 1;
    if (line_pulse && !lp_q) begin
      shifts <= s_cnt;
      period <= p_cnt;
      p_cnt <= 1;
      l_cnt <= l_cnt + 1;
    end
    if (!line_pulse && lp_q) begin
      width <= w_cnt;
      w_cnt <= 0;
      s_cnt <= 0;
    end
    if (frame_pulse && !fp_q) begin
      lines <= l_cnt;
      l_cnt <= 0;
    end
  end
endmodule
